//--- core/e1ais_defines.vh
// constants of the e1 ais alarm detector
// Notes on behaviour
// - detect ais when two frames hold under three zeros; framed skips slot 0
// - per 4 ms interval, thirteen of sixteen detections make a valid flag
// - each valid interval counts up; alarm declared at 25
// - each interval without flag counts down; alarm removed at zero
// - slot 16 detection: two all-ones slot 16 bytes while cas alignment lost
// - each valid slot 16 flag counts up; alarm declared at 22
// - no valid slot 16 flag counts down; alarm removed at zero
// - select field: 00 off, 01 unframed, 10 slot 16, 11 framed
// - change interrupt needs its own enable and the block enable
// - block enable zero suppresses every alarm status interrupt
// - declaring ais sets the read-only state bit
// - any state change sets a sticky change bit
// - reset-upon-read clears on read, else software writes to clear
// - change bit sits at bit 1 of the alarm status register
// - alarm present bit sits at bit 6 of the alarm status register
`ifndef E1AIS_DEFINES_VH
`define E1AIS_DEFINES_VH

// =====================================================
// register offsets
`define E1AIS_OFS_BLK_IEN    8'h01
`define E1AIS_OFS_STATUS     8'h02
`define E1AIS_OFS_ALM_IEN    8'h03
`define E1AIS_OFS_GEN_CTRL   8'h08
`define E1AIS_OFS_CLR_CTRL   8'h09

// =====================================================
// field positions
`define E1AIS_BIT_BLK_ALM    1
`define E1AIS_BIT_CHG        1
`define E1AIS_BIT_STATE      6
`define E1AIS_BIT_ALM_IEN    1
`define E1AIS_BIT_RUR        0

// =====================================================
// reset values
`define E1AIS_RST_REG        8'h00

// =====================================================
// detection select codes
`define E1AIS_SEL_OFF        2'h0
`define E1AIS_SEL_UNFRAMED   2'h1
`define E1AIS_SEL_TS16       2'h2
`define E1AIS_SEL_FRAMED     2'h3

// =====================================================
// frame layout and thresholds
`define E1AIS_LAST_SLOT      5'h1f
`define E1AIS_SLOT_FAS       5'h00
`define E1AIS_SLOT_SIG       5'h10
`define E1AIS_ZERO_LIMIT     4'h3
`define E1AIS_DET_NEEDED     5'h0d
`define E1AIS_DET_MAX        5'h10
`define E1AIS_AIS_DECLARE    5'h19
`define E1AIS_TS16_DECLARE   5'h16

// =====================================================
// timing
`define E1AIS_INTERVAL_US    4000
`define E1AIS_CLK_MHZ        100
`define E1AIS_INTERVAL_CYC   (`E1AIS_INTERVAL_US * `E1AIS_CLK_MHZ)

`endif

//--- core/e1ais_flag_counter.v
// up/down flag counter declaring and removing one alarm
`include "e1ais_defines.vh"

module e1ais_flag_counter #(
  parameter [4:0] THRESHOLD = `E1AIS_AIS_DECLARE
) (
  input  wire clock,
  input  wire sys_rst,
  input  wire tick,
  input  wire flagValid,
  output reg  alarm_q
);

  reg [4:0] cnt_q;
  reg [4:0] cnt_d;
  reg       alarm_d;

  // count toward threshold or back toward zero once per interval
  always @* begin
    cnt_d = cnt_q;
    if (tick) begin
      if (flagValid && cnt_q < THRESHOLD)
        cnt_d = cnt_q + 5'h01;
      else if (!flagValid && cnt_q != 5'h00)
        cnt_d = cnt_q - 5'h01;
    end
  end

  // declare at threshold, remove at zero, else hold
  always @* begin
    alarm_d = alarm_q;
    if (cnt_d == THRESHOLD)
      alarm_d = 1'b1;
    else if (cnt_d == 5'h00)
      alarm_d = 1'b0;
  end

  // state flops
  always @(posedge clock) begin
    if (sys_rst) begin
      cnt_q   <= 5'h00;
      alarm_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      alarm_q <= alarm_d;
    end
  end

endmodule

//--- core/e1ais_detector.v
// receive ais and slot 16 ais alarm detector with register file
`include "e1ais_defines.vh"

module e1ais_detector #(
  parameter INTERVAL_CYCLES = `E1AIS_INTERVAL_CYC
) (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  input  wire       regRdEn,
  output reg  [7:0] regRdData_q,
  input  wire       rxByteValid,
  input  wire [7:0] rxByte,
  input  wire [4:0] rxSlot,
  input  wire       casMfLost,
  output reg        irq_q,
  output reg        aisState_q
);

  // full-width last count, cut to the divider width on purpose
  localparam [31:0] INTERVAL_FULL = INTERVAL_CYCLES - 1;
  localparam [18:0] INTERVAL_LAST = INTERVAL_FULL[18:0];

  // =====================================================
  // helpers

  // zeros in one byte, four bits wide
  function [3:0] zeroCount;
    input [7:0] b;
    integer     i;
    begin
      zeroCount = 4'h0;
      for (i = 0; i < 8; i = i + 1)
        zeroCount = zeroCount + {3'h0, ~b[i]};
    end
  endfunction

  // saturating five-bit detection count
  function [4:0] satInc;
    input [4:0] v;
    input       en;
    begin
      satInc = (en && v < `E1AIS_DET_MAX) ? v + 5'h01 : v;
    end
  endfunction

  // =====================================================
  // registers

  reg  [7:0]  blkIen_q;
  reg  [7:0]  almIen_q;
  reg  [7:0]  genCtrl_q;
  reg  [7:0]  clrCtrl_q;
  reg         chgFlag_q;
  reg         chgFlag_d;

  wire [1:0]  detSel    = genCtrl_q[1:0];
  wire        rurMode   = clrCtrl_q[`E1AIS_BIT_RUR];
  wire        statusRd  = regRdEn && regAddr == `E1AIS_OFS_STATUS;
  wire        statusWr  = regWrEn && regAddr == `E1AIS_OFS_STATUS;

  // =====================================================
  // frame pair zero counting

  reg  [3:0]  pairZeros_q;
  reg         pairSecond_q;
  reg  [4:0]  aisDetCnt_q;
  reg  [3:0]  byteZeros;
  reg  [3:0]  sumZeros;
  wire        aisMode   = detSel == `E1AIS_SEL_UNFRAMED ||
                          detSel == `E1AIS_SEL_FRAMED;
  wire        skipByte  = detSel == `E1AIS_SEL_FRAMED &&
                          rxSlot == `E1AIS_SLOT_FAS;
  wire        frameEnd  = rxByteValid && rxSlot == `E1AIS_LAST_SLOT;
  wire        aisDet    = frameEnd && pairSecond_q && aisMode &&
                          sumZeros < `E1AIS_ZERO_LIMIT;

  // zeros of this byte added, saturating at fifteen
  always @* begin
    byteZeros = skipByte ? 4'h0 : zeroCount(rxByte);
    sumZeros  = pairZeros_q;
    if (rxByteValid)
      sumZeros = ({1'b0, pairZeros_q} + {1'b0, byteZeros} > 5'h0f) ?
                 4'hf : pairZeros_q + byteZeros;
  end

  // accumulate over two frames, restart after the pair
  always @(posedge clock) begin
    if (sys_rst) begin
      pairZeros_q  <= 4'h0;
      pairSecond_q <= 1'b0;
    end else if (rxByteValid) begin
      if (frameEnd && pairSecond_q)
        pairZeros_q <= 4'h0;
      else
        pairZeros_q <= sumZeros;
      if (frameEnd)
        pairSecond_q <= ~pairSecond_q;
    end
  end

  // =====================================================
  // slot 16 all-ones detection

  reg         prevSigOnes_q;
  reg  [4:0]  ts16DetCnt_q;
  wire        sigByte   = rxByteValid && rxSlot == `E1AIS_SLOT_SIG;
  wire        sigOnes   = rxByte == 8'hff;
  wire        ts16Det   = sigByte && sigOnes && prevSigOnes_q &&
                          casMfLost &&
                          detSel == `E1AIS_SEL_TS16;

  // remember whether the last slot 16 byte was all ones
  always @(posedge clock) begin
    if (sys_rst)
      prevSigOnes_q <= 1'b0;
    else if (sigByte)
      prevSigOnes_q <= sigOnes;
  end

  // =====================================================
  // interval timer and detection integration

  reg  [18:0] intervalCnt_q;
  reg         tick_q;
  wire        intervalEnd = intervalCnt_q == INTERVAL_LAST;
  wire        aisFlag  = aisDetCnt_q >= `E1AIS_DET_NEEDED;
  wire        ts16Flag = ts16DetCnt_q >= `E1AIS_DET_NEEDED;
  reg         aisFlag_q;
  reg         ts16Flag_q;

  // free running interval divider, one-cycle tick at its end
  always @(posedge clock) begin
    if (sys_rst) begin
      intervalCnt_q <= 19'h00000;
      tick_q        <= 1'b0;
    end else begin
      intervalCnt_q <= intervalEnd ? 19'h00000 :
                       intervalCnt_q + 19'h00001;
      tick_q        <= intervalEnd;
    end
  end

  // count detections per interval, latch flags at its end
  always @(posedge clock) begin
    if (sys_rst) begin
      aisDetCnt_q  <= 5'h00;
      ts16DetCnt_q <= 5'h00;
      aisFlag_q    <= 1'b0;
      ts16Flag_q   <= 1'b0;
    end else if (intervalEnd) begin
      aisDetCnt_q  <= 5'h00;
      ts16DetCnt_q <= 5'h00;
      aisFlag_q    <= aisFlag;
      ts16Flag_q   <= ts16Flag;
    end else begin
      aisDetCnt_q  <= satInc(aisDetCnt_q, aisDet);
      ts16DetCnt_q <= satInc(ts16DetCnt_q, ts16Det);
    end
  end

  // =====================================================
  // flag counters

  wire        aisAlarm;
  wire        ts16Alarm;

  // ais flag counter, declared at 25
  e1ais_flag_counter #(
    .THRESHOLD (`E1AIS_AIS_DECLARE)
  ) u_ais_cnt (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .tick      (tick_q),
    .flagValid (aisFlag_q),
    .alarm_q   (aisAlarm)
  );

  // slot 16 flag counter, declared at 22
  e1ais_flag_counter #(
    .THRESHOLD (`E1AIS_TS16_DECLARE)
  ) u_ts16_cnt (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .tick      (tick_q),
    .flagValid (ts16Flag_q),
    .alarm_q   (ts16Alarm)
  );

  // =====================================================
  // state, change flag and interrupt

  wire        alarmNow  = aisAlarm | ts16Alarm;
  wire        stateChg  = alarmNow != aisState_q;
  wire        rdClear   = statusRd && rurMode;
  wire        wrClear   = statusWr && !rurMode &&
                          regWrData[`E1AIS_BIT_CHG];

  // sticky change flag, a new change wins over a clear
  always @* begin
    chgFlag_d = chgFlag_q;
    if (rdClear || wrClear)
      chgFlag_d = 1'b0;
    if (stateChg)
      chgFlag_d = 1'b1;
  end

  // state bit, change flag and gated interrupt
  always @(posedge clock) begin
    if (sys_rst) begin
      aisState_q <= 1'b0;
      chgFlag_q  <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      aisState_q <= alarmNow;
      chgFlag_q  <= chgFlag_d;
      irq_q      <= chgFlag_d &&
                    almIen_q[`E1AIS_BIT_ALM_IEN] &&
                    blkIen_q[`E1AIS_BIT_BLK_ALM];
    end
  end

  // =====================================================
  // register writes

  // writable control registers
  always @(posedge clock) begin
    if (sys_rst) begin
      blkIen_q  <= `E1AIS_RST_REG;
      almIen_q  <= `E1AIS_RST_REG;
      genCtrl_q <= `E1AIS_RST_REG;
      clrCtrl_q <= `E1AIS_RST_REG;
    end else if (regWrEn) begin
      case (regAddr)
        `E1AIS_OFS_BLK_IEN:  blkIen_q  <= regWrData;
        `E1AIS_OFS_ALM_IEN:  almIen_q  <= regWrData;
        `E1AIS_OFS_GEN_CTRL: genCtrl_q <= regWrData;
        `E1AIS_OFS_CLR_CTRL: clrCtrl_q <= regWrData;
        default: ;
      endcase
    end
  end

  // =====================================================
  // register reads

  reg  [7:0]  statusWord;

  // status layout: change at bit 1, state at bit 6
  always @* begin
    statusWord = 8'h00;
    statusWord[`E1AIS_BIT_CHG]   = chgFlag_q;
    statusWord[`E1AIS_BIT_STATE] = aisState_q;
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clock) begin
    if (sys_rst)
      regRdData_q <= 8'h00;
    else if (regRdEn) begin
      case (regAddr)
        `E1AIS_OFS_BLK_IEN:  regRdData_q <= blkIen_q;
        `E1AIS_OFS_STATUS:   regRdData_q <= statusWord;
        `E1AIS_OFS_ALM_IEN:  regRdData_q <= almIen_q;
        `E1AIS_OFS_GEN_CTRL: regRdData_q <= genCtrl_q;
        `E1AIS_OFS_CLR_CTRL: regRdData_q <= clrCtrl_q;
        default:             regRdData_q <= 8'h00;
      endcase
    end else
      regRdData_q <= 8'h00;
  end

endmodule

//--- tb/e1ais_checker.sv
// assertion checker for the e1 ais alarm detector
module e1ais_checker #(
  parameter INTERVAL_CYCLES = 400000
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData_q,
  input wire logic       rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic [4:0] rxSlot,
  input wire logic       casMfLost,
  input wire logic       irq_q,
  input wire logic       aisState_q
);
  logic       blkEn_q, almEn_q, rurEn_q;
  logic [1:0] sel_q;
  int         offCnt_q;
  // ========================================
  // shadow of control fields, time spent with detection off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {blkEn_q, almEn_q, rurEn_q, sel_q} <= 5'h00;
      offCnt_q <= 0;
    end else begin
      if (regWrEn && regAddr == 8'h01) blkEn_q <= regWrData[1];
      if (regWrEn && regAddr == 8'h03) almEn_q <= regWrData[1];
      if (regWrEn && regAddr == 8'h09) rurEn_q <= regWrData[0];
      if (regWrEn && regAddr == 8'h08) sel_q <= regWrData[1:0];
      if (sel_q != 2'h0) offCnt_q <= 0;
      else if (offCnt_q < 2 * INTERVAL_CYCLES) offCnt_q <= offCnt_q + 1;
    end
  end
  // ========================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_block_gate: assert property (irq_q |-> $past(blkEn_q))
    else $error("irq high with block enable off");
  a_own_gate: assert property (irq_q |-> $past(almEn_q))
    else $error("irq high with alarm enable off");
  a_change_irq: assert property ($past(blkEn_q) && $past(almEn_q)
    && $changed(aisState_q) |-> irq_q) else $error("change without irq");
  a_rur_clear: assert property (rurEn_q && regRdEn && regAddr == 8'h02
    |=> (!irq_q || $changed(aisState_q))) else $error("read kept irq");
  a_wc_clear: assert property (!rurEn_q && regWrEn && regAddr == 8'h02
    && regWrData[1] |=> (!irq_q || $changed(aisState_q)))
    else $error("write kept irq");
  a_state_bit: assert property (regRdEn && regAddr == 8'h02
    |=> regRdData_q[6] == $past(aisState_q)) else $error("state bit wrong");
  a_status_layout: assert property (regRdEn && regAddr == 8'h02
    |=> (regRdData_q & 8'hbd) == 8'h00) else $error("stray status bits");
  a_off_quiet: assert property (offCnt_q > INTERVAL_CYCLES + 8
    && !aisState_q |=> !aisState_q) else $error("alarm with detection off");
  c_declare: cover property ($rose(aisState_q));
  c_remove: cover property ($fell(aisState_q));
  c_irq: cover property ($rose(irq_q));
endmodule

bind e1ais_detector e1ais_checker #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) i_chk (
  .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData_q(regRdData_q), .rxByteValid(rxByteValid), .rxByte(rxByte),
  .rxSlot(rxSlot), .casMfLost(casMfLost), .irq_q(irq_q),
  .aisState_q(aisState_q));

//--- tb/e1ais_rx_source.sv
// far-end e1 terminal sending the receive byte stream
module e1ais_rx_source (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [1:0] mode, // 0 live, 1 all ones, 2 framed, 3 slot 16
  output logic            rxByteValid,
  output logic [7:0]      rxByte,
  output logic [4:0]      rxSlot,
  output logic            casMfLost
);
  timeunit 1ns;
  timeprecision 1ps;
  int         seed = 32'h4b9c;
  logic [4:0] nxt;
  // ========================================
  // one byte a clock, slots in order 0..31
  assign nxt = rxSlot + 5'h01;
  initial {rxByteValid, rxByte, rxSlot, casMfLost} = 15'h03e0;
  always @(posedge clock) begin
    if (sys_rst) begin
      rxByteValid <= 1'b0;
      rxSlot <= 5'h1f;
      rxByte <= ~rxByte; // idle line keeps toggling
    end else begin
      rxByteValid <= 1'b1;
      rxSlot <= nxt;
      casMfLost <= (mode == 2'h3); // alignment lost in slot 16 ais
      case (mode)
        2'h1: rxByte <= 8'hff;
        2'h2: rxByte <= (nxt == 5'h00) ? 8'h1b : 8'hff; // framing kept
        2'h3: rxByte <= (nxt == 5'h10) ? 8'hff : 8'($random(seed));
        default: rxByte <= 8'($random(seed));
      endcase
    end
  end
endmodule

//--- tb/test_e1_ais_alarm_detector.sv
// self-checking bench of the e1 ais alarm detector
module test_e1_ais_alarm_detector;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IC = 900;
  logic       clock, sys_rst, regWrEn, regRdEn, rxByteValid, casMfLost;
  logic [7:0] regAddr, regWrData, regRdData_q, rxByte;
  logic [4:0] rxSlot;
  logic [1:0] mode;
  logic       irq_q, aisState_q;
  logic [7:0] mReg [256] = '{default: 8'h00};
  logic [7:0] adr [5] = '{8'h01, 8'h03, 8'h08, 8'h09, 8'h05};
  logic       mState, mChg;
  int         mismatches, n_compared, i, seed;
  // ========================================
  // design, far end and clock
  e1ais_detector #(.INTERVAL_CYCLES(IC)) i_dut (.clock(clock),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxSlot(rxSlot),
    .casMfLost(casMfLost), .irq_q(irq_q), .aisState_q(aisState_q));
  e1ais_rx_source i_src (.clock(clock), .sys_rst(sys_rst), .mode(mode),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxSlot(rxSlot),
    .casMfLost(casMfLost));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [7:0] mk(input logic [7:0] a);
    case (a)
      8'h01, 8'h03: mk = 8'h02;
      8'h08: mk = 8'h03;
      8'h09: mk = 8'h01;
      default: mk = 8'hff;
    endcase
  endfunction
  task automatic chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
    if (mk(a) != 8'hff) mReg[a] = d & mk(a);
    if (a == 8'h02 && d[1] && !mReg[9][0]) mChg = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1 chk(regRdData_q & mk(a), (a == 8'h02) ? {1'b0, mState, 4'h0, mChg,
      1'b0} : mReg[a]);
    if (a == 8'h02 && mReg[9][0]) mChg = 1'b0;
  endtask
  task automatic ci;
    repeat (2) @(posedge clock);
    #1 chk({7'h0, irq_q}, {7'h0, mChg & mReg[1][1] & mReg[3][1]});
  endtask
  task automatic phase(input logic [1:0] md, sel, input int n,
                       input logic st);
    @(posedge clock);
    mode <= md;
    wr(8'h08, {6'h00, sel});
    repeat ((n - 2) * IC) @(posedge clock);
    chk({7'h0, aisState_q}, {7'h0, mState});
    repeat (4 * IC) @(posedge clock);
    chk({7'h0, aisState_q}, {7'h0, st});
    mState = st;
    mChg = 1'b1;
    ci;
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ========================================
  // main sequence and watchdog
  initial begin
    {regWrEn, regRdEn, regAddr, regWrData, mode, mState, mChg} = '0;
    seed = 32'h4b9c;
    sys_rst = 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rd(8'h02);
    for (i = 0; i < 5; i++) rd(adr[i]);
    for (i = 0; i < 5; i++) begin
      wr(adr[i], 8'($random(seed)));
      rd(adr[i]);
    end
    wr(8'h01, 8'h02);
    wr(8'h03, 8'h02);
    wr(8'h09, 8'h00);
    phase(2'h2, 2'h3, 25, 1'b1);
    rd(8'h02);
    ci;
    wr(8'h02, 8'h02);
    ci;
    rd(8'h02);
    wr(8'h09, 8'h01);
    phase(2'h2, 2'h1, 25, 1'b0);
    rd(8'h02);
    ci;
    rd(8'h02);
    wr(8'h01, 8'h00);
    phase(2'h3, 2'h2, 22, 1'b1);
    wr(8'h01, 8'h02);
    ci;
    rd(8'h02);
    wr(8'h03, 8'h00);
    phase(2'h1, 2'h0, 22, 1'b0);
    rd(8'h02);
    close_out;
  end
  initial begin
    #980000;
    mismatches++;
    close_out;
  end
endmodule
